// ===== dv/cpuit_core_test.sv
// Self-checking bench for the instruction sequencing core.
// Assumes the program model answers within two clocks of an address change.
`timescale 1ns/100ps
module cpuit_core_test;
  import cpuit_pkg::*;
  logic sys_clk_i, nrst_i, hsel, hwrite, hready, dm_we, retire;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [PC_W-1:0] prog_addr;
  logic [INSTR_W-1:0] prog_data;
  logic [DM_AW-1:0] dm_addr;
  logic [DATA_W-1:0] dm_wdata;
  int failures = 0;
  int tests_run = 0;
  int ticks = 0;
  int gap = 0;
  int gaps[$];
  logic [15:0] writes[$];

  // Large watchdog period so no timeout hits a running program
  cpuit_core #(.WDT_CYCLES(4096)) i_cpuit_core (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(), .prog_addr_o(prog_addr), .prog_data_i(prog_data),
    .dm_we_o(dm_we), .dm_addr_o(dm_addr), .dm_wdata_o(dm_wdata), .wake_i(1'b0), .retire_o(retire));
  cpuit_prog_model i_cpuit_prog_model (.sys_clk_i(sys_clk_i), .addr_i(prog_addr), .data_o(prog_data));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Retire spacing and memory writes; gap stays 0 until the first retire
  always @(posedge sys_clk_i) begin
    ticks <= ticks + 1;
    gap <= (nrst_i !== 1'b1) ? 0 : (retire ? 1 : (gap > 0 ? gap + 1 : 0));
    if (retire === 1'b1 && gap > 0) gaps.push_back(gap);
    if (dm_we === 1'b1) writes.push_back({dm_addr, dm_wdata});
    if (ticks == 20000) begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One single AHB transfer; read data taken at the data-phase edge
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic put(input int a, input cpuit_op_t op, input logic [2:0] b, input logic [7:0] v);
    i_cpuit_prog_model.mem[a] = {op, b, v};
  endtask : put

  // Reset, start the core and poll until it halts
  task automatic start();
    nrst_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    gaps.delete();
    writes.delete();
    ahb(REG_CTRL, 1'b1, 32'h1);
    rd = 32'h0;
    for (int i = 0; i < 100 && rd[ST_HALTED_BIT] !== 1'b1; i++) ahb(REG_STATUS, 1'b0, 32'h0);
  endtask : start

  task automatic check_run(input int eg[], input logic [15:0] ew[]);
    chk(gaps.size(), eg.size());
    foreach (eg[i]) chk(gaps[i], eg[i]);
    chk(writes.size(), ew.size());
    foreach (ew[i]) chk(writes[i], ew[i]);
  endtask : check_run

  task automatic arith_flow();
    foreach (i_cpuit_prog_model.mem[i]) i_cpuit_prog_model.mem[i] = 16'h0;
    put(0, op_transfer_i2a, 3'h0, 8'hf0);
    put(1, op_add_i, 3'h0, 8'h20);
    put(2, op_transfer_a2m, 3'h0, 8'h10);
    put(3, op_add_one_in_place, 3'h0, 8'h10);
    put(4, op_bit_set, 3'h7, 8'h10);
    put(5, op_rotate_left_thru_carry, 3'h0, 8'h10);
    put(6, op_jump_unconditional, 3'h0, 8'h08);
    put(7, op_transfer_a2m, 3'h0, 8'h30);
    put(8, op_halt, 3'h0, 8'h00);
    put(9, op_watchdog_clear_op, 3'h0, 8'h00);
    put(10, op_jump_unconditional, 3'h0, 8'h0a);
    start();
    // four clocks, jump two cycles, writes in order
    check_run('{4, 4, 4, 4, 4, 4, 8}, '{16'h1010, 16'h1011, 16'h1091, 16'h1023});
    ahb(REG_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h1e, 32'h16);
    ahb(REG_ACC, 1'b0, 32'h0);
    chk(rd & 32'hff, 32'h10);
    ahb(REG_CTRL, 1'b1, 32'h3);
    // A write leaves the last read word in rd, so force at least one poll
    rd[ST_PDOWN_BIT] = 1'b1;
    for (int i = 0; i < 20 && rd[ST_PDOWN_BIT] !== 1'b0; i++) ahb(REG_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h1c, 32'h0);
  endtask : arith_flow

  task automatic flow_ctrl();
    foreach (i_cpuit_prog_model.mem[i]) i_cpuit_prog_model.mem[i] = 16'h0;
    put(0, op_transfer_i2a, 3'h0, 8'h00);
    put(1, op_transfer_a2m, 3'h0, 8'h20);
    put(2, op_skip_zero, 3'h0, 8'h20);
    put(3, op_transfer_i2a, 3'h0, 8'h55);
    put(4, op_call, 3'h0, 8'h10);
    put(5, op_transfer_a2m, 3'h0, 8'h21);
    put(6, op_transfer_i2a, 3'h0, 8'h09);
    put(7, op_transfer_a2m, 3'h0, PROG_CNT_LOW_BYTE_ADDR);
    put(8, op_transfer_a2m, 3'h0, 8'h22);
    put(9, op_halt, 3'h0, 8'h00);
    put(16, op_add_one_to_accum, 3'h0, 8'h20);
    put(17, op_subroutine_exit, 3'h0, 8'h00);
    start();
    // taken skip, call, return and low-byte write
    check_run('{4, 4, 8, 8, 4, 8, 4, 4, 8}, '{16'h2000, 16'h2101});
    ahb(REG_ACC, 1'b0, 32'h0);
    chk(rd & 32'hff, 32'h09);
  endtask : flow_ctrl

  task automatic tbl_logic();
    foreach (i_cpuit_prog_model.mem[i]) i_cpuit_prog_model.mem[i] = 16'h0;
    i_cpuit_prog_model.mem[{TABLE_PAGE, 8'h05}] = 16'hab5c;
    put(0, op_transfer_i2a, 3'h0, 8'h05);
    put(1, op_transfer_a2m, 3'h0, TABLE_PTR_ADDR);
    put(2, op_table_read, 3'h0, 8'h40);
    put(3, op_sub_i, 3'h0, 8'h06);
    put(4, op_rotate_right_thru_carry, 3'h0, 8'h40);
    put(5, op_transfer_m2a, 3'h0, 8'h40);
    put(6, op_xor_m, 3'h0, 8'h40);
    put(7, op_skip_bit_zero, 3'h0, 8'h40);
    put(8, op_transfer_i2a, 3'h0, 8'h77);
    put(9, op_bit_clear, 3'h3, 8'h40);
    put(10, op_call, 3'h0, 8'h20);
    put(11, op_halt, 3'h0, 8'h00);
    put(32, op_interrupt_exit, 3'h0, 8'h00);
    start();
    // table word lands, borrow rotates in, xor gives zero
    check_run('{4, 4, 8, 4, 4, 4, 4, 8, 4, 8, 8}, '{16'h405c, 16'h40ae, 16'h40a6});
    ahb(REG_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h3, 32'h1);
    ahb(REG_ACC, 1'b0, 32'h0);
    chk(rd & 32'hffff, 32'hab00);
  endtask : tbl_logic

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  initial begin
    nrst_i = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    arith_flow();
    flow_ctrl();
    tbl_logic();
    finish_test();
  end
endmodule : cpuit_core_test

// ===== dv/cpuit_prog_model.sv
// Program memory model: a word array that the bench fills before each run.
// Assumes the core holds prog_addr_o for a whole instruction cycle.
`timescale 1ns/100ps
module cpuit_prog_model #(
  parameter int LAT = 2
) (
  // Clock
  input wire logic sys_clk_i,
  // Fetch port
  input wire logic [cpuit_pkg::PC_W-1:0] addr_i,
  output logic [cpuit_pkg::INSTR_W-1:0] data_o
);
  import cpuit_pkg::*;
  logic [INSTR_W-1:0] mem [2048];
  logic [INSTR_W-1:0] stage;
  // Slowest legal answer by default: one register, valid for the second edge
  always_ff @(posedge sys_clk_i) begin
    stage <= mem[addr_i];
  end
  always_comb begin
    data_o = (LAT == 1) ? mem[addr_i] : stage;
  end
endmodule : cpuit_prog_model

// ===== inc/cpuit_pkg.sv
// Constants, opcodes and register map of the instruction sequencing core.
// Assumes a 16-bit program word and byte-wide data memory on one clock.
package cpuit_pkg;
  // Widths
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int INSTR_W = 16;
  localparam int DM_AW = 8;
  localparam int STACK_DEPTH_DEF = 4;
  // Four system clocks make one instruction cycle
  localparam int CLK_PER_CYCLE = 4;
  localparam logic [1:0] PH_FIRST = 2'h0;
  localparam logic [1:0] PH_LATCH = 2'h1;
  localparam logic [1:0] PH_EXEC = 2'(CLK_PER_CYCLE - 1);
  // Instruction fields: opcode [15:11], bit index [10:8], operand [7:0]
  localparam int OP_LSB = 11;
  localparam int BIT_LSB = 8;
  localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;
  localparam logic [2:0] TABLE_PAGE = 3'h7;
  // Data addresses decoded by the core itself
  localparam logic [DM_AW-1:0] PROG_CNT_LOW_BYTE_ADDR = 8'h00;
  localparam logic [DM_AW-1:0] TABLE_PTR_ADDR = 8'h01;
  // Watchdog period in system clocks
  localparam int WDT_DEFAULT = 65536;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_ACC = 8'h0c;
  // Register fields and reset values
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam logic CTRL_RUN_RESET = 1'b0;
  localparam int ST_ZERO_BIT = 0;
  localparam int ST_CARRY_BIT = 1;
  localparam int ST_PDOWN_BIT = 2;
  localparam int ST_TMO_BIT = 3;
  localparam int ST_HALTED_BIT = 4;
  localparam int ST_BUBBLE_BIT = 5;
  localparam int TBLH_LSB = 8;
  // Opcodes, numbered in order from zero
  typedef enum logic [4:0] {
    op_nop, op_transfer_m2a, op_transfer_a2m, op_transfer_i2a,
    op_add_m, op_add_i, op_sub_m, op_sub_i,
    op_and_m, op_or_m, op_xor_m, op_bitwise_invert,
    op_bitwise_invert_a, op_add_one_in_place, op_add_one_to_accum, op_subtract_one_in_place,
    op_subtract_one_to_accum, op_rotate_right, op_rotate_left, op_rotate_right_thru_carry,
    op_rotate_left_thru_carry, op_bit_set, op_bit_clear, op_skip_zero,
    op_skip_bit_zero, op_jump_unconditional, op_call, op_subroutine_exit,
    op_interrupt_exit, op_table_read, op_halt, op_watchdog_clear_op
  } cpuit_op_t;
endpackage : cpuit_pkg

// ===== rtl/cpuit_core.sv
// 8-bit core sequencer: fetch, execute and instruction-cycle timing, AHB-Lite status.
// Assumes program memory answers prog_addr_o within two clocks; wake_i is asynchronous.
// Notes on behaviour
// - One instruction cycle is four system clocks.
// - Ordinary instructions complete in one cycle.
// - Jump, call, returns, table read take two.
// - Writing low program counter jumps, adds cycle.
// - Taken skip adds cycle, skips next instruction.
// - Add/subtract give 8 bits, carry/borrow flag.
// - Increment/decrement by one, to memory or accumulator.
// - Logic results of zero set zero flag.
// - Rotates move one bit, optionally through carry.
// - Call saves next address; return resumes there.
// - Jump loads target, saves no return.
// - Bit set/clear changes only that bit.
// - Table read moves low byte to memory, high byte to tblh.
// - Three transfer forms: m2a, a2m, immediate.
// - Halt powers down; separate watchdog clear.
// - Watchdog clear clears timeout and powerdown flags.
`timescale 1ns/100ps
module cpuit_core #(
  parameter int WDT_CYCLES = cpuit_pkg::WDT_DEFAULT,
  parameter int STACK_DEPTH = cpuit_pkg::STACK_DEPTH_DEF
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Program memory fetch
  output logic [cpuit_pkg::PC_W-1:0] prog_addr_o,
  input wire logic [cpuit_pkg::INSTR_W-1:0] prog_data_i,
  // Data memory write activity
  output logic dm_we_o,
  output logic [cpuit_pkg::DM_AW-1:0] dm_addr_o,
  output logic [cpuit_pkg::DATA_W-1:0] dm_wdata_o,
  // Wake pin and retire strobe
  input wire logic wake_i,
  output logic retire_o
);
  import cpuit_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam logic [31:0] WDT_LAST = 32'(WDT_CYCLES - 1);

  // Stack pointer wraps, so depth must be a power of two
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH || WDT_CYCLES < 2) begin : g_bad_param
    $error("cpuit_core: unsupported parameter values");
  end

  logic [1:0] ph;
  logic bub, run, halted, active, exec, bub_end;
  logic [PC_W-1:0] pc, tgt, next_pc, stk_top;
  logic [INSTR_W-1:0] ir, tdat;
  logic [DATA_W-1:0] acc, tblp, tblh, rdata, opnd, res, b_in, bmask, imm;
  logic [DATA_W:0] sum9, dif9;
  logic z, c, pdown, tmo, next_c;
  logic wm, wa, uz, bb, push, pop, hlt, wclr;
  cpuit_op_t op;
  logic [DM_AW-1:0] maddr;
  logic [2:0] bi;
  logic [PC_W-1:0] stk [STACK_DEPTH];
  logic [SP_W-1:0] sp;
  logic s1, s2, s3, wake_lvl, wake_q, wake_ev, wake_sw, wdt_to;
  logic [31:0] wdt_cnt;
  logic ap, wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] rd_mux;

  // Instruction fields
  assign op = cpuit_op_t'(ir[INSTR_W-1:OP_LSB]);
  assign maddr = ir[DM_AW-1:0];
  assign imm = ir[DATA_W-1:0];
  assign bi = ir[OP_LSB-1:BIT_LSB];
  assign tgt = ir[PC_W-1:0];
  assign bmask = 8'h01 << bi;

  // Sequencing strobes
  assign active = run && !halted;
  assign exec = active && ph == PH_EXEC && !bub;
  assign bub_end = active && ph == PH_EXEC && bub;
  assign retire_o = exec;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph <= PH_FIRST;
    end else if (active) begin
      ph <= (ph == PH_EXEC) ? PH_FIRST : ph + 2'h1;
    end
  end

  // Fetch latch; in a bubble the slot is latched into tdat instead of ir, which is table data after a table read
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ir <= '0;
      tdat <= '0;
    end else if (active && ph == PH_LATCH) begin
      if (bub) begin
        tdat <= prog_data_i;
      end else begin
        ir <= prog_data_i;
      end
    end
  end

  // Operand source; core-held bytes shadow memory
  always_comb begin
    if (maddr == PROG_CNT_LOW_BYTE_ADDR) begin
      opnd = pc[7:0];
    end else if (maddr == TABLE_PTR_ADDR) begin
      opnd = tblp;
    end else begin
      opnd = rdata;
    end
  end

  assign b_in = (op == op_add_i || op == op_sub_i) ? imm : opnd;
  assign sum9 = {1'b0, acc} + {1'b0, b_in};
  assign dif9 = {1'b0, acc} - {1'b0, b_in};
  assign stk_top = stk[sp - SP_W'(1)];

  // Execute decode
  always_comb begin
    res = opnd;
    next_c = c;
    wm = 1'b0;
    wa = 1'b0;
    uz = 1'b0;
    next_pc = pc + 11'h001;
    bb = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    hlt = 1'b0;
    wclr = 1'b0;
    case (op)
      op_transfer_m2a: wa = 1'b1;
      op_transfer_a2m: begin
        res = acc;
        wm = 1'b1;
      end
      op_transfer_i2a: begin
        res = imm;
        wa = 1'b1;
      end
      // carry above 255, borrow below zero
      op_add_m, op_add_i: begin
        {next_c, res} = sum9;
        wa = 1'b1;
        uz = 1'b1;
      end
      op_sub_m, op_sub_i: begin
        {next_c, res} = dif9;
        wa = 1'b1;
        uz = 1'b1;
      end
      op_and_m: begin
        res = acc & opnd;
        wa = 1'b1;
        uz = 1'b1;
      end
      op_or_m: begin
        res = acc | opnd;
        wa = 1'b1;
        uz = 1'b1;
      end
      op_xor_m: begin
        res = acc ^ opnd;
        wa = 1'b1;
        uz = 1'b1;
      end
      op_bitwise_invert: begin
        res = ~opnd;
        wm = 1'b1;
        uz = 1'b1;
      end
      op_bitwise_invert_a: begin
        res = ~opnd;
        wa = 1'b1;
        uz = 1'b1;
      end
      // step by one, memory or accumulator
      op_add_one_in_place: begin
        res = opnd + 8'h01;
        wm = 1'b1;
        uz = 1'b1;
      end
      op_add_one_to_accum: begin
        res = opnd + 8'h01;
        wa = 1'b1;
        uz = 1'b1;
      end
      op_subtract_one_in_place: begin
        res = opnd - 8'h01;
        wm = 1'b1;
        uz = 1'b1;
      end
      op_subtract_one_to_accum: begin
        res = opnd - 8'h01;
        wa = 1'b1;
        uz = 1'b1;
      end
      op_rotate_right: begin
        res = {opnd[0], opnd[7:1]};
        wm = 1'b1;
      end
      op_rotate_left: begin
        res = {opnd[6:0], opnd[7]};
        wm = 1'b1;
      end
      op_rotate_right_thru_carry: begin
        res = {c, opnd[7:1]};
        next_c = opnd[0];
        wm = 1'b1;
      end
      op_rotate_left_thru_carry: begin
        res = {opnd[6:0], c};
        next_c = opnd[7];
        wm = 1'b1;
      end
      op_bit_set: begin
        res = opnd | bmask;
        wm = 1'b1;
      end
      op_bit_clear: begin
        res = opnd & ~bmask;
        wm = 1'b1;
      end
      // taken skip steps over next word
      op_skip_zero: begin
        if (opnd == 8'h00) begin
          next_pc = pc + 11'h002;
          bb = 1'b1;
        end
      end
      op_skip_bit_zero: begin
        if ((opnd & bmask) == 8'h00) begin
          next_pc = pc + 11'h002;
          bb = 1'b1;
        end
      end
      op_jump_unconditional: begin
        next_pc = tgt;
        bb = 1'b1;
      end
      op_call: begin
        next_pc = tgt;
        push = 1'b1;
        bb = 1'b1;
      end
      op_subroutine_exit, op_interrupt_exit: begin
        next_pc = stk_top;
        pop = 1'b1;
        bb = 1'b1;
      end
      // table data arrives in the bubble
      op_table_read: bb = 1'b1;
      op_halt: hlt = 1'b1;
      op_watchdog_clear_op: wclr = 1'b1;
      default: res = opnd;
    endcase
    // low program counter write is a jump
    if (wm && maddr == PROG_CNT_LOW_BYTE_ADDR) begin
      next_pc = {pc[PC_W-1:8], res};
      bb = 1'b1;
    end
  end

  // bubble only when decode asks for it
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc <= RESET_VECTOR;
      bub <= 1'b0;
    end else if (exec) begin
      pc <= next_pc;
      bub <= bb;
    end else if (bub_end) begin
      bub <= 1'b0;
    end
  end

  // Fetch address; table read borrows the bubble's fetch slot
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prog_addr_o <= RESET_VECTOR;
    end else if (exec) begin
      prog_addr_o <= (op == op_table_read) ? {TABLE_PAGE, tblp} : next_pc;
    end else if (bub_end) begin
      prog_addr_o <= pc;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc <= '0;
      z <= 1'b0;
      c <= 1'b0;
    end else if (exec) begin
      if (wa) begin
        acc <= res;
      end
      if (uz) begin
        z <= (res == 8'h00);
      end
      c <= next_c;
    end
  end

  // Table pointer and high byte of the last table word
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tblp <= '0;
      tblh <= '0;
    end else if (exec && wm && maddr == TABLE_PTR_ADDR) begin
      tblp <= res;
    end else if (bub_end && op == op_table_read) begin
      tblh <= tdat[INSTR_W-1:TBLH_LSB];
    end
  end

  // Memory write; registered so the write lands before the next read phase
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dm_we_o <= 1'b0;
      dm_addr_o <= '0;
      dm_wdata_o <= '0;
    end else begin
      dm_we_o <= 1'b0;
      if (exec && wm && maddr != PROG_CNT_LOW_BYTE_ADDR && maddr != TABLE_PTR_ADDR) begin
        dm_we_o <= 1'b1;
        dm_addr_o <= maddr;
        dm_wdata_o <= res;
      end else if (bub_end && op == op_table_read) begin
        // low byte of table word to memory
        dm_we_o <= 1'b1;
        dm_addr_o <= maddr;
        dm_wdata_o <= tdat[DATA_W-1:0];
      end
    end
  end

  cpuit_dmem #(
    .AW(DM_AW),
    .DW(DATA_W)
  ) u_dmem (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .we_i(dm_we_o),
    .waddr_i(dm_addr_o),
    .wdata_i(dm_wdata_o),
    .raddr_i(maddr),
    .rdata_o(rdata)
  );

  // Stack pointer; overflow wraps silently, like the real stack
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sp <= '0;
    end else if (exec && push) begin
      sp <= sp + SP_W'(1);
    end else if (exec && pop) begin
      sp <= sp - SP_W'(1);
    end
  end

  // return address is the word after the call
  always_ff @(posedge sys_clk_i) begin
    if (exec && push) begin
      stk[sp] <= pc + 11'h001;
    end
  end

  // Wake pin synchroniser; level accepted once stages two and three agree
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      wake_lvl <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      s1 <= wake_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        wake_lvl <= s3;
      end
      wake_q <= wake_lvl;
    end
  end
  assign wake_ev = wake_lvl && !wake_q;

  // Watchdog counter, restarted by clear, halt or its own timeout
  assign wdt_to = (wdt_cnt == WDT_LAST);
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdt_cnt <= '0;
    end else if (wdt_to || (exec && (wclr || hlt))) begin
      wdt_cnt <= '0;
    end else begin
      wdt_cnt <= wdt_cnt + 32'h1;
    end
  end

  // clear wipes both flags; timeout set beats a clear
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmo <= 1'b0;
      pdown <= 1'b0;
    end else begin
      if (wdt_to) begin
        tmo <= 1'b1;
      end else if (exec && (wclr || hlt)) begin
        tmo <= 1'b0;
      end
      if (exec && hlt) begin
        pdown <= 1'b1;
      end else if (exec && wclr) begin
        pdown <= 1'b0;
      end
    end
  end

  // halt stops the sequencer until a wake source
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      halted <= 1'b0;
    end else if (exec && hlt) begin
      halted <= 1'b1;
    end else if (wake_ev || wdt_to || wake_sw) begin
      halted <= 1'b0;
    end
  end

  // AHB-Lite: zero wait states, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign ap = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= ap && hwrite_i;
      wr_addr <= haddr_i[7:0];
    end
  end

  // Control register; wake bit is a self-clearing pulse
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run <= CTRL_RUN_RESET;
      wake_sw <= 1'b0;
    end else begin
      wake_sw <= 1'b0;
      if (wr_pend && wr_addr == REG_CTRL) begin
        run <= hwdata_i[CTRL_RUN_BIT];
        wake_sw <= hwdata_i[CTRL_WAKE_BIT];
      end
    end
  end

  // Read decode; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0;
    if (haddr_i[7:0] == REG_CTRL) begin
      rd_mux[CTRL_RUN_BIT] = run;
    end else if (haddr_i[7:0] == REG_STATUS) begin
      rd_mux[ST_ZERO_BIT] = z;
      rd_mux[ST_CARRY_BIT] = c;
      rd_mux[ST_PDOWN_BIT] = pdown;
      rd_mux[ST_TMO_BIT] = tmo;
      rd_mux[ST_HALTED_BIT] = halted;
      rd_mux[ST_BUBBLE_BIT] = bub;
    end else if (haddr_i[7:0] == REG_PC) begin
      rd_mux[PC_W-1:0] = pc;
    end else if (haddr_i[7:0] == REG_ACC) begin
      rd_mux[DATA_W-1:0] = acc;
      rd_mux[TBLH_LSB+DATA_W-1:TBLH_LSB] = tblh;
    end
  end

  // Read data sampled in the address phase, held until the next read
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_o <= '0;
    end else if (ap && !hwrite_i) begin
      hrdata_o <= rd_mux;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  one_cycle_a: assert property (exec && !bb && !hlt |=> !exec [*3] ##1 (exec || !active))
    else $error("ordinary instruction not four clocks");
  ordinary_single_a: assert property (exec && !bb |=> !bub)
    else $error("ordinary instruction took a bubble");
  two_cycle_a: assert property (exec && (op == op_jump_unconditional || op == op_call
      || op == op_subroutine_exit || op == op_interrupt_exit || op == op_table_read)
      |=> !exec [*7] ##1 (exec || !active))
    else $error("branch class not eight clocks");
  pcl_jump_a: assert property (exec && wm && maddr == PROG_CNT_LOW_BYTE_ADDR
      |=> bub && pc[7:0] == $past(res))
    else $error("low counter write not a jump");
  skip_taken_a: assert property (exec && op == op_skip_zero && opnd == 8'h00
      |=> bub && pc == $past(pc) + 11'h002)
    else $error("taken skip wrong");
  add_carry_a: assert property (exec && op == op_add_m |=> {c, acc} == $past(sum9))
    else $error("add result or carry wrong");
  inc_accum_a: assert property (exec && op == op_add_one_to_accum
      |=> acc == $past(opnd) + 8'h01)
    else $error("increment to accumulator wrong");
  logic_zero_a: assert property (exec && (op == op_and_m || op == op_or_m || op == op_xor_m)
      |=> z == (acc == 8'h00))
    else $error("zero flag wrong after logic");
  rot_carry_a: assert property (exec && op == op_rotate_right_thru_carry
      |=> c == $past(opnd[0]))
    else $error("rotate carry wrong");
  call_save_a: assert property (exec && op == op_call |=> stk_top == $past(pc) + 11'h001)
    else $error("call saved wrong address");
  jump_load_a: assert property (exec && op == op_jump_unconditional
      |=> pc == $past(tgt) && $stable(sp))
    else $error("jump target or stack wrong");
  bit_set_a: assert property (exec && op == op_bit_set && maddr > TABLE_PTR_ADDR
      |=> dm_we_o && dm_wdata_o == ($past(opnd) | $past(bmask)))
    else $error("bit set changed other bits");
  halt_entry_a: assert property (exec && op == op_halt |=> halted && pdown && !retire_o)
    else $error("halt did not power down");
  wdt_clear_a: assert property (exec && op == op_watchdog_clear_op && !wdt_to
      |=> !tmo && !pdown)
    else $error("watchdog clear left flags");
endmodule : cpuit_core

// ===== rtl/cpuit_dmem.sv
// Byte-wide data memory with registered read data.
// Assumes one clock; a write and a read of one address in one cycle return old data.
`timescale 1ns/100ps
module cpuit_dmem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [1 << AW];

  // Storage has no reset, contents undefined until written
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule : cpuit_dmem
